// *** design/dif_filter.sv ***
`timescale 1ns/100ps
`default_nettype none

module dbf_filter #(
  parameter int unsigned TICK_CYCLES_P = dbf_pkg::TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [dbf_pkg::LINE_COUNT-1:0] DIN,
  input wire logic CFG_VALID,
  input wire logic [dbf_pkg::SEL_W-1:0] CFG_LINE,
  input wire logic [15:0] CFG_CONST,
  output logic CFG_REJECT,
  output logic [dbf_pkg::LINE_COUNT-1:0] DOUT,
  output logic TICK
);
  import dbf_pkg::*;

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES_P - 1);
  localparam logic [TICK_CNT_W-1:0] TICK_STEP = TICK_CNT_W'(32'h1);
  localparam dbf_const_t COUNT_STEP = 15'h0001;
  localparam logic [CONST_W:0] WIDE_STEP = 16'h0001;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Selector zero addresses every line
  function automatic logic line_hit(input logic [SEL_W-1:0] sel, input int unsigned idx);
    line_hit = (sel == SEL_ALL_LINES) || (sel == SEL_W'(idx + 1));
  endfunction : line_hit

  // Constant fits the unsigned 15-bit range
  function automatic logic const_in_range(input logic [15:0] value);
    const_in_range = (value[CONST_W] == 1'b0);
  endfunction : const_in_range

  // True once one more tick reaches the limit
  function automatic logic accept_step(input dbf_const_t count, input dbf_const_t limit);
    accept_step = (({1'b0, count} + WIDE_STEP) >= {1'b0, limit});
  endfunction : accept_step

  // Saturating step towards zero
  function automatic dbf_const_t count_down(input dbf_const_t count);
    if (count == '0) begin
      count_down = '0;
    end else begin
      count_down = count - COUNT_STEP;
    end
  endfunction : count_down

  // One step towards the limit
  function automatic dbf_const_t count_up(input dbf_const_t count);
    count_up = count + COUNT_STEP;
  endfunction : count_up

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  logic [LINE_COUNT-1:0] meta_q;
  logic [LINE_COUNT-1:0] sync_q;

  // First stage, read only by the second
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_q <= '0;
    end else begin
      meta_q <= DIN;
    end
  end

  // Second stage, the only copy the filters read
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync_q <= '0;
    end else begin
      sync_q <= meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Tick generator
  // ----------------------------------------------------------------
  logic [TICK_CNT_W-1:0] tick_cnt_q;
  logic [TICK_CNT_W-1:0] tick_cnt_d;
  logic tick_wrap;
  logic tick_q;

  // Free-running count of clock cycles per tick
  assign tick_wrap = (tick_cnt_q >= TICK_LAST);

  always_comb begin
    if (tick_wrap) begin
      tick_cnt_d = '0;
    end else begin
      tick_cnt_d = tick_cnt_q + TICK_STEP;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // One-cycle pulse, drives every filter
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Configuration command
  // ----------------------------------------------------------------
  logic cfg_ok;
  wire logic [LINE_COUNT-1:0] load_hit;

  // Out-of-range constants are dropped and flagged
  assign cfg_ok = CFG_VALID && const_in_range(CFG_CONST);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CFG_REJECT <= 1'b0;
    end else begin
      CFG_REJECT <= CFG_VALID && !cfg_ok;
    end
  end

  for (genvar h = 0; h < LINE_COUNT; h++) begin : g_hit
    assign load_hit[h] = cfg_ok && line_hit(CFG_LINE, h);
  end

  // ----------------------------------------------------------------
  // Per-line integrating filters
  // ----------------------------------------------------------------
  wire logic [LINE_COUNT-1:0] level_w;

  for (genvar g = 0; g < LINE_COUNT; g++) begin : g_line
    dbf_const_t const_q;
    dbf_const_t count_q;
    dbf_const_t count_d;
    logic level_q;
    logic level_d;
    logic differs;
    logic reach;

    assign differs = (sync_q[g] != level_q);
    assign reach = accept_step(count_q, const_q);

    // Constant for this line
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        const_q <= CONST_RESET;
      end else if (load_hit[g]) begin
        const_q <= CFG_CONST[CONST_W-1:0];
      end
    end

    // Old level pulls the count down, new level pushes it up
    always_comb begin
      count_d = count_q;
      level_d = level_q;
      if (tick_q) begin
        if (!differs) begin
          count_d = count_down(count_q);
        end else if (reach) begin
          count_d = '0;
          level_d = sync_q[g];
        end else begin
          count_d = count_up(count_q);
        end
      end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        count_q <= '0;
      end else begin
        count_q <= count_d;
      end
    end

    // Reported level, changes only on an accepting tick
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        level_q <= 1'b0;
      end else begin
        level_q <= level_d;
      end
    end

    assign level_w[g] = level_q;
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  assign DOUT = level_w;
  assign TICK = tick_q;

endmodule : dbf_filter

`default_nettype wire

// *** pkg/dif_pkg.sv ***
`default_nettype none
package dbf_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned LINE_COUNT = 7;
  localparam int unsigned CONST_W = 15;
  localparam int unsigned SEL_W = 3;

  // ----------------------------------------------------------------
  // Selector codes and reset values
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_ALL_LINES = 3'h0;
  localparam logic [CONST_W-1:0] CONST_RESET = 15'h0053;
  localparam logic [CONST_W-1:0] CONST_MAX = 15'h7fff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TICK_PERIOD_US = 120;
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TICK_CNT_W = $clog2(TICK_CYCLES);

  typedef logic [CONST_W-1:0] dbf_const_t;

endpackage : dbf_pkg
`default_nettype wire

// *** tb/dbf_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module dbf_props #(parameter int P = 4) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CFG_VALID,
  input wire logic [15:0] CFG_CONST,
  input wire logic CFG_REJECT,
  input wire logic [6:0] DOUT,
  input wire logic TICK
);
  // ----------------------------------------------------------------
  // Tick spacing helper
  // ----------------------------------------------------------------
  logic [31:0] gap_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gap_q <= 32'h0;
    end else if (TICK) begin
      gap_q <= 32'h1;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  tick_pulse_a: assert property (TICK |=> !TICK) else $error("tick long");
  tick_rate_a: assert property (TICK |-> gap_q == 32'(P)) else $error("tick rate");
  tick_gap_a: assert property (gap_q <= 32'(P)) else $error("tick gap");
  out_on_tick_a: assert property (!$stable(DOUT) |-> $past(TICK)) else $error("dout");
  bad_reject_a: assert property (CFG_VALID && CFG_CONST[15] |=> CFG_REJECT)
    else $error("no reject");
  reject_cause_a: assert property (CFG_REJECT |-> $past(CFG_VALID && CFG_CONST[15]))
    else $error("stray reject");
  cover property (CFG_REJECT);
  cover property ($rose(DOUT[0]));
  cover property (TICK && DOUT[1]);
endmodule : dbf_props
bind dbf_filter dbf_props #(.P(TICK_CYCLES_P)) dbf_props_i (.CLK(CLK), .RST_N(RST_N),
  .CFG_VALID(CFG_VALID), .CFG_CONST(CFG_CONST), .CFG_REJECT(CFG_REJECT), .DOUT(DOUT), .TICK(TICK));
`default_nettype wire

// *** tb/dbf_switches.sv ***
`timescale 1ns/100ps
`default_nettype none
module dbf_switches (
  input wire logic [6:0] LVL,
  output logic [6:0] DIN
);
  assign DIN = LVL;
endmodule : dbf_switches
`default_nettype wire

// *** tb/digital_input_debounce_filter_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module digital_input_debounce_filter_tb;
  logic clk = 0, rst_n = 0, vld = 0, rej, tick, rj;
  logic [6:0] lvl = 0, din, dout;
  logic [2:0] sel = 0;
  logic [15:0] cv = 0;
  int errors = 0, n_tests = 0;
  always #20 clk = ~clk;
  dbf_switches dbf_switches_i (.LVL(lvl), .DIN(din));
  dbf_filter #(.TICK_CYCLES_P(4)) dbf_filter_i (.CLK(clk), .RST_N(rst_n), .DIN(din),
    .CFG_VALID(vld), .CFG_LINE(sel), .CFG_CONST(cv), .CFG_REJECT(rej), .DOUT(dout), .TICK(tick));
  task automatic ck(input logic [6:0] e);
    n_tests++;
    if (dout !== e) begin
      errors++;
      $display("[ERR] DOUT exp %h got %h", e, dout);
    end
  endtask : ck
  task automatic cfg(input logic [2:0] s, input logic [15:0] c);
    @(negedge clk); vld = 1; sel = s; cv = c;
    @(negedge clk); vld = 0; rj = rej;
    @(negedge clk); rj = rj | rej; n_tests++;
    if (rj !== c[15]) begin
      errors++;
      $display("[ERR] CFG_REJECT exp %b got %b", c[15], rj);
    end
  endtask : cfg
  // Level set after each tick, sampled at the following one
  task automatic t(input logic [6:0] v, input int n);
    repeat (n) begin @(posedge clk iff tick); @(negedge clk); lvl = v; end
  endtask : t
  task results;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    #200000 errors++;
    results();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    ck(7'h00);
    cfg(3'h0, 16'h0008);
    cfg(3'h0, 16'h8000);
    cfg(3'h2, 16'h0000);
    t(7'h00, 1);
    t(7'h02, 2);
    ck(7'h02);
    $display("config test done");
    t(7'h43, 5);
    t(7'h02, 2);
    t(7'h43, 5);
    ck(7'h02);
    t(7'h43, 1);
    ck(7'h43);
    $display("filter test done");
    results();
  end
endmodule : digital_input_debounce_filter_tb
`default_nettype wire
